// ==== core/gdfc_defines.vh ====
/*
 * constants of the gate-drive fault configuration slice: register offsets,
 * field positions, reset values and timing counts at a 5 ns clock.
 * assumes it is included by its bare name from the design file.
 */
`ifndef GDFC_DEFINES_VH
`define GDFC_DEFINES_VH

// ----------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------
`define GDFC_ADDR_LS_CURRENT   4'h7
`define GDFC_ADDR_TIMING_MON   4'h8
`define GDFC_ADDR_OC_MON       4'h9

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define GDFC_RST_LS_CURRENT    8'hff
`define GDFC_RST_TIMING_MON    8'h20
`define GDFC_RST_OC_MON        8'h20

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define GDFC_SRC_MSB           7
`define GDFC_SRC_LSB           4
`define GDFC_SNK_MSB           3
`define GDFC_SNK_LSB           0
`define GDFC_GMODE_MSB         7
`define GDFC_GMODE_LSB         6
`define GDFC_TDRV_MSB          5
`define GDFC_TDRV_LSB          4
`define GDFC_TDEAD_MSB         3
`define GDFC_TDEAD_LSB         1
`define GDFC_GIND_BIT          0
`define GDFC_OMODE_MSB         7
`define GDFC_OMODE_LSB         6
`define GDFC_DG_MSB            5
`define GDFC_DG_LSB            4
`define GDFC_PD_MSB            3
`define GDFC_PD_LSB            2
`define GDFC_THR_BIT           1
`define GDFC_OIND_BIT          0

// ----------------------------------------------------------------------
// encodings
// ----------------------------------------------------------------------
`define GDFC_MODE_LATCH        2'h0
`define GDFC_MODE_CYCLE        2'h1
`define GDFC_MODE_WARN         2'h2
`define GDFC_MODE_OFF          2'h3
`define GDFC_BRG_HALF          2'h0
`define GDFC_BRG_PHEN          2'h1
`define GDFC_BRG_PWM           2'h2
`define GDFC_BRG_SPLIT         2'h3
`define GDFC_CODE_8MA          4'h6
`define GDFC_CODE_31MA         4'hc
`define GDFC_CODE_62MA         4'hf

// ----------------------------------------------------------------------
// times in their own units and derived cycle counts
// ----------------------------------------------------------------------
`define GDFC_CLK_NS            5
`define GDFC_CYC(ns)           (((ns) + `GDFC_CLK_NS - 1) / `GDFC_CLK_NS)
`define GDFC_TDRV_96_US        96
`define GDFC_TDRV_2_US         2
`define GDFC_TDRV_4_US         4
`define GDFC_TDRV_8_US         8
`define GDFC_DG_1_US           1
`define GDFC_DG_2_US           2
`define GDFC_DG_4_US           4
`define GDFC_DG_8_US           8
`define GDFC_DEAD_STEP_NS      250
`define GDFC_DEAD_2000_NS      2000
`define GDFC_DEAD_4000_NS      4000
`define GDFC_DEAD_8000_NS      8000

`endif

// ==== core/gdfc_regs.v ====
/*
 * gate-drive fault configuration slice: three 8-bit registers holding
 * low-side current codes, gate monitor / timing and overcurrent monitor
 * settings, plus the fault qualification and shutdown logic they steer.
 * assumes a serial front end that presents decoded register accesses
 * as one-cycle strobes, and monitor inputs synchronous to clk_sys.
 */
`timescale 1ns/1ps
`default_nettype none
`include "gdfc_defines.vh"

module gdfc_regs #(
    parameter [14:0] TDRV_96_CYC = `GDFC_CYC(`GDFC_TDRV_96_US * 1000)
) (
    // clock and reset
    input  wire       clk_sys,
    input  wire       reset,
    // register access
    input  wire [3:0] regAddr,
    input  wire [7:0] regWrData,
    input  wire       regWrEn,
    input  wire       regRdEn,
    output reg  [7:0] regRdData_ff,
    output reg        regRdHit_ff,
    // bridge and monitor inputs
    input  wire [1:0] bridge_input_control_mode,
    input  wire       switchEdge,
    input  wire [1:0] gateFaultRaw,
    input  wire [1:0] overcurrentRaw,
    input  wire       faultClear,
    // drive controls
    output reg  [3:0] lowside_source_current_code_ff,
    output reg  [3:0] lowside_sink_current_code_ff,
    output reg        gate_monitor_threshold_sel_ff,
    output reg        deadTimeActive_ff,
    output reg        blankingActive_ff,
    output reg  [1:0] halfBridgeOff_ff,
    // fault reporting
    output reg  [1:0] gateFaultLatched_ff,
    output reg  [1:0] ocFaultLatched_ff,
    output reg        gateWarning_ff,
    output reg        ocWarning_ff
);

    // ------------------------------------------------------------------
    // helper functions
    // ------------------------------------------------------------------
    // drive / blanking time in cycles
    function [14:0] tdrvCycles;
        input [1:0]  code;
        reg   [31:0] cyc;
        begin
            case (code)
                2'h0:    cyc = {17'h00000, TDRV_96_CYC};
                2'h1:    cyc = `GDFC_CYC(`GDFC_TDRV_2_US * 1000);
                2'h2:    cyc = `GDFC_CYC(`GDFC_TDRV_4_US * 1000);
                default: cyc = `GDFC_CYC(`GDFC_TDRV_8_US * 1000);
            endcase
            tdrvCycles = cyc[14:0]; // all counts fit the timer width
        end
    endfunction

    // inserted dead-time in cycles, 0 disables it
    function [10:0] deadCycles;
        input [2:0]  code;
        reg   [31:0] cyc;
        begin
            case (code)
                3'h0:    cyc = 32'h0;
                3'h1:    cyc = `GDFC_CYC(`GDFC_DEAD_STEP_NS);
                3'h2:    cyc = `GDFC_CYC(`GDFC_DEAD_STEP_NS * 2);
                3'h3:    cyc = `GDFC_CYC(`GDFC_DEAD_STEP_NS * 3);
                3'h4:    cyc = `GDFC_CYC(`GDFC_DEAD_STEP_NS * 4);
                3'h5:    cyc = `GDFC_CYC(`GDFC_DEAD_2000_NS);
                3'h6:    cyc = `GDFC_CYC(`GDFC_DEAD_4000_NS);
                default: cyc = `GDFC_CYC(`GDFC_DEAD_8000_NS);
            endcase
            deadCycles = cyc[10:0];
        end
    endfunction

    // overcurrent deglitch in cycles
    function [10:0] dgCycles;
        input [1:0]  code;
        reg   [31:0] cyc;
        begin
            case (code)
                2'h0:    cyc = `GDFC_CYC(`GDFC_DG_1_US * 1000);
                2'h1:    cyc = `GDFC_CYC(`GDFC_DG_2_US * 1000);
                2'h2:    cyc = `GDFC_CYC(`GDFC_DG_4_US * 1000);
                default: cyc = `GDFC_CYC(`GDFC_DG_8_US * 1000);
            endcase
            dgCycles = cyc[10:0];
        end
    endfunction

    // halves hit by a fault in half idx: own half only when independent in half or split bridge mode
    function [1:0] shutMask;
        input       indBit;
        input [1:0] brg;
        input       idx;
        begin
            if (indBit && (brg == `GDFC_BRG_HALF ||
                           brg == `GDFC_BRG_SPLIT)) begin
                shutMask = idx ? 2'h2 : 2'h1;
            end else begin
                shutMask = 2'h3;
            end
        end
    endfunction

    // ------------------------------------------------------------------
    // registers: written copy for readback, active copy for the logic
    // ------------------------------------------------------------------
    reg  [7:0] lsCur_ff;
    reg  [7:0] tmMon_ff;
    reg  [7:0] ocMon_ff;
    reg  [7:0] actLs_ff;
    reg  [7:0] actTm_ff;
    reg  [7:0] actOc_ff;

    // host writes land in the written copy at once
    always @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            lsCur_ff <= `GDFC_RST_LS_CURRENT;
            tmMon_ff <= `GDFC_RST_TIMING_MON;
            ocMon_ff <= `GDFC_RST_OC_MON;
        end else if (regWrEn) begin
            case (regAddr)
                `GDFC_ADDR_LS_CURRENT: lsCur_ff <= regWrData;
                `GDFC_ADDR_TIMING_MON: tmMon_ff <= regWrData;
                `GDFC_ADDR_OC_MON:     ocMon_ff <= regWrData;
                default: ;
            endcase
        end
    end

    // readback of the last written value; unmapped reads return zero
    always @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            regRdData_ff <= 8'h00;
            regRdHit_ff  <= 1'b0;
        end else if (regRdEn) begin
            regRdHit_ff <= 1'b1;
            case (regAddr)
                `GDFC_ADDR_LS_CURRENT: regRdData_ff <= lsCur_ff;
                `GDFC_ADDR_TIMING_MON: regRdData_ff <= tmMon_ff;
                `GDFC_ADDR_OC_MON:     regRdData_ff <= ocMon_ff;
                default: begin
                    regRdData_ff <= 8'h00;
                    regRdHit_ff  <= 1'b0;
                end
            endcase
        end else begin
            regRdHit_ff <= 1'b0;
        end
    end

    // settings move to the active copy only at a switching edge, so a
    // write never changes current or timing in the middle of a transition
    always @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            actLs_ff <= `GDFC_RST_LS_CURRENT;
            actTm_ff <= `GDFC_RST_TIMING_MON;
            actOc_ff <= `GDFC_RST_OC_MON;
        end else if (switchEdge) begin
            actLs_ff <= lsCur_ff;
            actTm_ff <= tmMon_ff;
            actOc_ff <= ocMon_ff;
        end
    end

    // ------------------------------------------------------------------
    // field views of the active copy
    // ------------------------------------------------------------------
    wire [1:0] gateMode = actTm_ff[`GDFC_GMODE_MSB:`GDFC_GMODE_LSB];
    wire [1:0] tdrvCode = actTm_ff[`GDFC_TDRV_MSB:`GDFC_TDRV_LSB];
    wire [2:0] deadCode = actTm_ff[`GDFC_TDEAD_MSB:`GDFC_TDEAD_LSB];
    wire       gateInd  = actTm_ff[`GDFC_GIND_BIT];
    wire [1:0] ocMode   = actOc_ff[`GDFC_OMODE_MSB:`GDFC_OMODE_LSB];
    wire [1:0] dgCode   = actOc_ff[`GDFC_DG_MSB:`GDFC_DG_LSB];
    wire [1:0] pdCode   = actOc_ff[`GDFC_PD_MSB:`GDFC_PD_LSB];
    wire       ocInd    = actOc_ff[`GDFC_OIND_BIT];

    // ------------------------------------------------------------------
    // dead-time and drive / blanking timers
    // ------------------------------------------------------------------
    reg  [10:0] deadCnt_ff;
    reg  [14:0] blankCnt_ff;
    wire [10:0] nxt_deadCnt;
    wire [14:0] nxt_blankCnt;

    // timers restart on each switching edge using the settings just made
    // active, which is why they decode the written copy at that edge
    assign nxt_deadCnt = switchEdge ?
        deadCycles(tmMon_ff[`GDFC_TDEAD_MSB:`GDFC_TDEAD_LSB]) :
        ((deadCnt_ff != 11'h000) ? deadCnt_ff - 11'h001 : 11'h000);
    assign nxt_blankCnt = switchEdge ?
        tdrvCycles(tmMon_ff[`GDFC_TDRV_MSB:`GDFC_TDRV_LSB]) :
        ((blankCnt_ff != 15'h0000) ? blankCnt_ff - 15'h0001 : 15'h0000);

    always @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            deadCnt_ff        <= 11'h000;
            blankCnt_ff       <= 15'h0000;
            deadTimeActive_ff <= 1'b0;
            blankingActive_ff <= 1'b0;
        end else begin
            deadCnt_ff        <= nxt_deadCnt;
            blankCnt_ff       <= nxt_blankCnt;
            deadTimeActive_ff <= (nxt_deadCnt != 11'h000);
            blankingActive_ff <= (nxt_blankCnt != 15'h0000);
        end
    end

    // ------------------------------------------------------------------
    // fault qualification per half-bridge
    // ------------------------------------------------------------------
    reg  [10:0] dgCnt_ff [0:1];
    reg  [1:0]  ocSeen_ff;
    reg  [1:0]  gateSeen_ff;
    reg  [1:0]  cycleOff_ff;
    reg         pulldownOvr_ff;
    reg  [1:0]  ocEvt;
    reg  [1:0]  gateEvt;
    reg  [1:0]  nxt_latched;
    reg  [1:0]  nxt_cycle;
    reg  [1:0]  nxt_gateLat;
    reg  [1:0]  nxt_ocLat;
    reg         nxt_gateWarn;
    reg         nxt_ocWarn;
    integer     i;
    integer     j;

    // monitors sleep while blanking; an event fires once per assertion
    always @* begin
        nxt_gateLat  = faultClear ? 2'h0 : gateFaultLatched_ff;
        nxt_ocLat    = faultClear ? 2'h0 : ocFaultLatched_ff;
        nxt_latched  = nxt_gateLat | nxt_ocLat;
        nxt_cycle    = switchEdge ? 2'h0 : cycleOff_ff;
        nxt_gateWarn = gateWarning_ff & ~faultClear;
        nxt_ocWarn   = ocWarning_ff & ~faultClear;
        for (i = 0; i < 2; i = i + 1) begin
            ocEvt[i]   = overcurrentRaw[i] && !blankingActive_ff &&
                         ocMode != `GDFC_MODE_OFF && !ocSeen_ff[i] &&
                         dgCnt_ff[i] + 11'h001 >= dgCycles(dgCode);
            gateEvt[i] = gateFaultRaw[i] && !blankingActive_ff &&
                         gateMode != `GDFC_MODE_OFF && !gateSeen_ff[i];
            // events are applied after the clears, so a set wins
            if (gateEvt[i]) begin
                case (gateMode)
                    `GDFC_MODE_LATCH: nxt_gateLat = nxt_gateLat |
                        shutMask(gateInd, bridge_input_control_mode,
                                 i[0]);
                    `GDFC_MODE_CYCLE: nxt_cycle = nxt_cycle |
                        shutMask(gateInd, bridge_input_control_mode,
                                 i[0]);
                    `GDFC_MODE_WARN: nxt_gateWarn = 1'b1;
                    default: ;
                endcase
            end
            if (ocEvt[i]) begin
                case (ocMode)
                    `GDFC_MODE_LATCH: nxt_ocLat = nxt_ocLat |
                        shutMask(ocInd, bridge_input_control_mode,
                                 i[0]);
                    `GDFC_MODE_CYCLE: nxt_cycle = nxt_cycle |
                        shutMask(ocInd, bridge_input_control_mode,
                                 i[0]);
                    `GDFC_MODE_WARN: nxt_ocWarn = 1'b1;
                    default: ;
                endcase
            end
        end
        nxt_latched = nxt_gateLat | nxt_ocLat;
    end

    // deglitch counters and per-assertion guards
    always @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            dgCnt_ff[0] <= 11'h000;
            dgCnt_ff[1] <= 11'h000;
            ocSeen_ff   <= 2'h0;
            gateSeen_ff <= 2'h0;
        end else begin
            for (j = 0; j < 2; j = j + 1) begin
                if (!overcurrentRaw[j] || blankingActive_ff) begin
                    dgCnt_ff[j] <= 11'h000;
                end else if (dgCnt_ff[j] != 11'h7ff) begin
                    dgCnt_ff[j] <= dgCnt_ff[j] + 11'h001;
                end
                ocSeen_ff[j]   <= overcurrentRaw[j] &
                                  (ocSeen_ff[j] | ocEvt[j]);
                gateSeen_ff[j] <= gateFaultRaw[j] &
                                  (gateSeen_ff[j] | gateEvt[j]);
            end
        end
    end

    // ------------------------------------------------------------------
    // shutdown, warnings and drive outputs
    // ------------------------------------------------------------------
    always @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            gateFaultLatched_ff <= 2'h0;
            ocFaultLatched_ff   <= 2'h0;
            cycleOff_ff         <= 2'h0;
            halfBridgeOff_ff    <= 2'h0;
            gateWarning_ff      <= 1'b0;
            ocWarning_ff        <= 1'b0;
            pulldownOvr_ff      <= 1'b0;
        end else begin
            gateFaultLatched_ff <= nxt_gateLat;
            ocFaultLatched_ff   <= nxt_ocLat;
            cycleOff_ff         <= nxt_cycle;
            halfBridgeOff_ff    <= nxt_latched | nxt_cycle;
            gateWarning_ff      <= nxt_gateWarn;
            ocWarning_ff        <= nxt_ocWarn;
            // override set by an overcurrent shutdown holds while any gate or overcurrent shutdown is in force
            if (|ocEvt && (ocMode == `GDFC_MODE_LATCH ||
                           ocMode == `GDFC_MODE_CYCLE)) begin
                pulldownOvr_ff <= 1'b1;
            end else if ((nxt_latched | nxt_cycle) == 2'h0) begin
                pulldownOvr_ff <= 1'b0;
            end
        end
    end

    // source code and threshold follow the active copy; the sink code does too unless the override forces a pdCode pulldown value
    always @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            lowside_source_current_code_ff <= 4'hf;
            lowside_sink_current_code_ff   <= 4'hf;
            gate_monitor_threshold_sel_ff  <= 1'b0;
        end else begin
            lowside_source_current_code_ff <=
                actLs_ff[`GDFC_SRC_MSB:`GDFC_SRC_LSB];
            gate_monitor_threshold_sel_ff <=
                actOc_ff[`GDFC_THR_BIT];
            if (pulldownOvr_ff && pdCode != 2'h0) begin
                case (pdCode)
                    2'h1:    lowside_sink_current_code_ff <=
                                 `GDFC_CODE_8MA;
                    2'h2:    lowside_sink_current_code_ff <=
                                 `GDFC_CODE_31MA;
                    default: lowside_sink_current_code_ff <=
                                 `GDFC_CODE_62MA;
                endcase
            end else begin
                lowside_sink_current_code_ff <=
                    actLs_ff[`GDFC_SNK_MSB:`GDFC_SNK_LSB];
            end
        end
    end

endmodule // gdfc_regs
`default_nettype wire

// ==== verif/gdfc_checker.sv ====
/*
 * concurrent checks on the gate-drive fault configuration slice ports.
 * assumes one clock domain, clk_sys, and an active-high async reset.
 */
`timescale 1ns/1ps
`default_nettype none
// ---------------------------------------------------------------
// port checker
// ---------------------------------------------------------------
module gdfc_checker (
    // clock and reset
    input wire logic       clk_sys,
    input wire logic       reset,
    // register access
    input wire logic [3:0] regAddr,
    input wire logic       regRdEn,
    input wire logic [7:0] regRdData_ff,
    input wire logic       regRdHit_ff,
    // monitor inputs
    input wire logic       switchEdge,
    input wire logic       faultClear,
    input wire logic [1:0] gateFaultRaw,
    input wire logic [1:0] overcurrentRaw,
    // drive and fault outputs
    input wire logic [3:0] lowside_source_current_code_ff,
    input wire logic       gate_monitor_threshold_sel_ff,
    input wire logic       blankingActive_ff,
    input wire logic [1:0] gateFaultLatched_ff,
    input wire logic [1:0] ocFaultLatched_ff,
    input wire logic       gateWarning_ff,
    input wire logic       ocWarning_ff
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (reset);
    // only indices 7..9 hold registers
    wire mapped = (regAddr >= 4'h7) && (regAddr <= 4'h9);

    chk_rd_mapped: assert property (
        regRdEn && mapped |=> regRdHit_ff)
        else $error("mapped read gave no hit");
    chk_rd_unmapped: assert property (
        regRdEn && !mapped |=> !regRdHit_ff && regRdData_ff == 8'h00)
        else $error("unmapped read not refused");
    chk_hit_pulse: assert property (
        !regRdEn |=> !regRdHit_ff)
        else $error("hit without a read");
    // settings may only move two cycles after a switching edge
    chk_src_hold: assert property (
        !$past(switchEdge, 2) |-> $stable(lowside_source_current_code_ff))
        else $error("source code moved without switching edge");
    chk_thr_hold: assert property (
        !$past(switchEdge, 2) |-> $stable(gate_monitor_threshold_sel_ff))
        else $error("threshold moved without switching edge");
    chk_blank_start: assert property (
        switchEdge |=> blankingActive_ff)
        else $error("blanking did not start");
    chk_blank_cause: assert property (
        $rose(blankingActive_ff) |-> $past(switchEdge))
        else $error("blanking started on its own");
    chk_clear_all: assert property (
        faultClear && gateFaultRaw == 2'h0 && overcurrentRaw == 2'h0
        |=> gateFaultLatched_ff == 2'h0 && ocFaultLatched_ff == 2'h0
        && !gateWarning_ff && !ocWarning_ff)
        else $error("clear left a fault standing");
    chk_oc_deglitch: assert property (
        $rose(|ocFaultLatched_ff) |->
        $past(|overcurrentRaw) && $past(|overcurrentRaw, 8))
        else $error("overcurrent latched without persistence");
    chk_gate_blank: assert property (
        $rose(|gateFaultLatched_ff) |->
        $past(|gateFaultRaw) && !$past(blankingActive_ff))
        else $error("gate fault latched while blanked or absent");
endmodule // gdfc_checker

bind gdfc_regs gdfc_checker u_gdfc_checker (.*);
`default_nettype wire

// ==== verif/gdfc_host_model.sv ====
/*
 * host side of the register port: one-cycle write and read strobes.
 * assumes calls start 1 ns after a rising clk_sys edge.
 */
`timescale 1ns/1ps
`default_nettype none
// ---------------------------------------------------------------
// register host
// ---------------------------------------------------------------
module gdfc_host_model (
    // clock
    input  wire logic       clk_sys,
    // register access
    output var  logic [3:0] regAddr,
    output var  logic [7:0] regWrData,
    output var  logic       regWrEn,
    output var  logic       regRdEn,
    input  wire logic [7:0] regRdData_ff,
    input  wire logic       regRdHit_ff
);
    initial begin
        regAddr = 4'h0;
        regWrData = 8'h00;
        regWrEn = 1'b0;
        regRdEn = 1'b0;
    end
    // idle cycle after each strobe so a strobe never drops and rises at once
    task wr(input logic [3:0] a, input logic [7:0] d);
        regAddr = a;
        regWrData = d;
        regWrEn = 1'b1;
        @(posedge clk_sys);
        #1;
        regWrEn = 1'b0;
        regWrData = ~d; // released data must not look valid
        @(posedge clk_sys);
        #1;
    endtask
    task rd(input logic [3:0] a, output logic [7:0] d, output logic h);
        regAddr = a;
        regRdEn = 1'b1;
        @(posedge clk_sys);
        #1;
        d = regRdData_ff;
        h = regRdHit_ff;
        regRdEn = 1'b0;
        @(posedge clk_sys);
        #1;
    endtask
endmodule // gdfc_host_model
`default_nettype wire

// ==== verif/gate_drive_fault_config_regs_tb_top.sv ====
/*
 * self-checking bench: reset values, readback, timers and fault modes.
 * assumes the design core and the host model compile alongside.
 */
`timescale 1ns/1ps
`default_nettype none
`include "gdfc_defines.vh"
// ---------------------------------------------------------------
// bench top
// ---------------------------------------------------------------
module gate_drive_fault_config_regs_tb_top;
    localparam int TDRV = 40; // shortened 96 us drive time
    logic clk_sys, reset, switchEdge, faultClear;
    logic [1:0] bridge_input_control_mode, gateFaultRaw, overcurrentRaw;
    wire [3:0] regAddr, srcCode, snkCode;
    wire [7:0] regWrData, regRdData_ff;
    wire regWrEn, regRdEn, regRdHit_ff, thrSel, deadAct, blankAct;
    wire gWarn, oWarn;
    wire [1:0] hbOff, gLat, oLat;
    int error_cnt, total_checks, model [7:9];
    logic [31:0] lfsr = 32'h1081;

    gdfc_regs #(.TDRV_96_CYC(15'd40)) u_gdfc_regs (.clk_sys(clk_sys),
        .reset(reset), .regAddr(regAddr), .regWrData(regWrData),
        .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData_ff(regRdData_ff),
        .regRdHit_ff(regRdHit_ff), .switchEdge(switchEdge),
        .bridge_input_control_mode(bridge_input_control_mode),
        .gateFaultRaw(gateFaultRaw), .overcurrentRaw(overcurrentRaw),
        .faultClear(faultClear), .lowside_source_current_code_ff(srcCode),
        .lowside_sink_current_code_ff(snkCode),
        .gate_monitor_threshold_sel_ff(thrSel), .deadTimeActive_ff(deadAct),
        .blankingActive_ff(blankAct), .halfBridgeOff_ff(hbOff),
        .gateFaultLatched_ff(gLat), .ocFaultLatched_ff(oLat),
        .gateWarning_ff(gWarn), .ocWarning_ff(oWarn));
    gdfc_host_model u_gdfc_host_model (.clk_sys(clk_sys),
        .regAddr(regAddr), .regWrData(regWrData), .regWrEn(regWrEn),
        .regRdEn(regRdEn), .regRdData_ff(regRdData_ff),
        .regRdHit_ff(regRdHit_ff));

    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end
    // hang guard, well above the longest expected run
    initial begin
        repeat (40000) @(posedge clk_sys);
        error_cnt++;
        end_sim();
    end

    function automatic logic [31:0] nxtLfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task check(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task end_sim();
        if (error_cnt == 0 && total_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    task do_reset();
        reset = 1'b1;
        tick(3);
        reset = 1'b0;
        model[7] = 8'hff;
        model[8] = 8'h20;
        model[9] = 8'h20;
    endtask
    task sw();
        switchEdge = 1'b1;
        tick(1);
        switchEdge = 1'b0;
    endtask
    task wr(input logic [3:0] a, input logic [7:0] d);
        u_gdfc_host_model.wr(a, d);
        if (a >= 4'h7 && a <= 4'h9) model[a] = d;
    endtask
    task rdchk(input logic [3:0] a);
        logic [7:0] d;
        logic h;
        u_gdfc_host_model.rd(a, d, h);
        check(d, (a >= 4'h7 && a <= 4'h9) ? model[a] : 0);
        check(h, a >= 4'h7 && a <= 4'h9);
    endtask
    // one fault on one half, then check masks, flags and clear
    task fault_case(input bit oc, input logic [1:0] m, b, g);
        int n;
        logic [1:0] msk;
        logic [3:0] pdTab [4];
        pdTab = '{4'h5, `GDFC_CODE_8MA, `GDFC_CODE_31MA, `GDFC_CODE_62MA};
        do_reset();
        bridge_input_control_mode = b;
        wr(`GDFC_ADDR_LS_CURRENT, 8'h35);
        wr(`GDFC_ADDR_TIMING_MON, oc ? 8'hc0 : {m, 5'h00, 1'b1});
        wr(`GDFC_ADDR_OC_MON, oc ? {m, g, g, 2'b01} : 8'hc0);
        sw();
        tick(TDRV + 4);
        msk = (b == 2'h0 || b == 2'h3) ? (oc ? 2'h2 : 2'h1) : 2'h3;
        n = oc ? 200 << g : 1;
        if (oc) overcurrentRaw = 2'h2;
        else gateFaultRaw = 2'h1;
        tick(n - 1);
        check({gLat, oLat, hbOff}, 0);
        tick(1);
        check(oc ? oLat : gLat, m == 2'h0 ? msk : 0);
        check(oc ? gLat : oLat, 0);
        check(hbOff, m < 2'h2 ? msk : 0);
        check(oc ? oWarn : gWarn, m == 2'h2);
        if (oc && m < 2'h2) begin
            tick(2);
            check(snkCode, pdTab[g]);
        end
        gateFaultRaw = 2'h0;
        overcurrentRaw = 2'h0;
        faultClear = 1'b1;
        tick(1);
        faultClear = 1'b0;
        tick(1);
        check({gLat, oLat, gWarn, oWarn}, 0);
    endtask

    initial begin
        int dc, bc;
        int deadNs [8];
        int tdrvUs [4];
        deadNs = '{0, 250, 500, 750, 1000, 2000, 4000, 8000};
        tdrvUs = '{0, 2, 4, 8};
        switchEdge = 1'b0;
        faultClear = 1'b0;
        bridge_input_control_mode = 2'h0;
        gateFaultRaw = 2'h0;
        overcurrentRaw = 2'h0;
        do_reset();
        for (int a = 6; a <= 10; a++) rdchk(a);
        check({srcCode, snkCode, 7'h00, thrSel}, 16'hff00);
        repeat (3) begin
            wr(4'h3, lfsr[7:0]);
            for (int a = 7; a <= 9; a++) begin
                lfsr = nxtLfsr(lfsr);
                wr(a, lfsr[7:0]);
                rdchk(a);
            end
        end
        wr(`GDFC_ADDR_LS_CURRENT, lfsr[15:8]);
        wr(`GDFC_ADDR_OC_MON, lfsr[23:16]);
        check(srcCode, 4'hf);
        sw();
        tick(2);
        check(srcCode, model[7][7:4]);
        check(snkCode, model[7][3:0]);
        check(thrSel, model[9][1]);
        // every dead-time and drive-time code, counted in cycles
        for (int i = 0; i < 8; i++) begin
            wr(`GDFC_ADDR_TIMING_MON, {2'h3, i[1:0], i[2:0], 1'b0});
            dc = 0;
            bc = 0;
            switchEdge = 1'b1;
            for (int k = 0; k < 1800; k++) begin
                tick(1);
                switchEdge = 1'b0;
                dc += deadAct;
                bc += blankAct;
            end
            check(dc, deadNs[i] / 5);
            check(bc, i % 4 == 0 ? TDRV : tdrvUs[i % 4] * 200);
        end
        for (int m = 0; m < 4; m++)
            for (int b = 0; b < 4; b++) fault_case(0, m, b, 0);
        for (int i = 0; i < 4; i++) fault_case(1, i, i, i);
        fault_case(1, 0, 3, 2);
        fault_case(1, 1, 0, 3);
        end_sim();
    end
endmodule // gate_drive_fault_config_regs_tb_top
`default_nettype wire
